// ===== design/temp_alarm.sv
/*
  result formatting, critical alarm and multipurpose alarm pin logic of a
  two-channel temperature monitor, with an AXI4-Lite register slave.
  assumes conversion results arrive synchronous to clk_in, one per pulse.
*/
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// What this block does
// R1 - standard scale: below zero codes 00h
// R2 - standard scale: above 127 saturates 7Fh
// R3 - config bit 2 selects extended scale
// R4 - scale change applies from next conversion
// R5 - extended scale adds 64 to temperature
// R6 - critical pin has no software disable
// R7 - config bit 5 picks alert or critical
// R8 - critical pin low beyond critical limit
// R9 - critical release below limit minus hysteresis; the block releases at or below it
// R10 - second critical uses high/low limits
// R11 - alert low on high/low limit violation
// R12 - alert needs one to four consecutive violations
// R13 - alert low on open remote diode
// R14 - config bit 7 suppresses alert pin
// R15 - address read releases alert, clears flags; the block does so only once no limit violation or open diode remains
// R16 - diode fault keeps result, sets bit
// R17 - invalid supply skips conversion, keeps result
// R18 - scale change leaves limits untouched
// R19 - remote 1/16 degree, local selectable resolution
// R20 - alarms evaluated at each conversion completion
module temp_alarm
    import temp_alarm_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire axil_req_s axil_req_in,
    output axil_rsp_s axil_rsp_out,
    input wire conv_s conv_in,
    input wire logic supply_ok_in,
    output logic critical_overtemp_pin_out,
    output logic critical_overtemp_pin_oe_out,
    output logic second_critical_pin_out,
    output logic second_critical_pin_oe_out
);

    typedef struct packed {
        axil_rsp_s rsp;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [7:0] w_byte;
        logic w_en;
        logic [7:0] cfg;
        logic [LIM_N-1:0][7:0] lim;
        logic [7:0] hyst;
        logic [1:0] consec;
        logic [1:0][15:0] temp;
        logic [1:0] crit_hit;
        logic [1:0] sec_hit;
        logic [1:0][1:0] cnt;
        logic [1:0] viol_now;
        logic open_now;
        logic [7:0] stat;
        logic pin_lvl;
        logic crit_oe;
        logic p6_oe;
    } state_s;

    state_s q;
    state_s d;
    logic signed [8:0] ip;
    logic signed [9:0] ex;
    logic [7:0] code_std;
    logic [7:0] code_ext;
    logic [7:0] code;
    logic [7:0] frac;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] cr;
    logic vh;
    logic vl;
    logic ch;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic [7:0] rd_idx;

    always_comb begin
        d = q;
        ch = conv_in.remote;
        ip = signed'(conv_in.temp[12:4]);
        ex = 10'(ip) + EXT_OFFSET;
        // [R1] [R2]
        if (ip < 0) begin
            code_std = CODE_MIN;
        end else if (ip > signed'({1'b0, CODE_STD_MAX})) begin
            code_std = CODE_STD_MAX;
        end else begin
            code_std = ip[7:0];
        end
        // [R5]
        if (ex < 0) begin
            code_ext = CODE_MIN;
        end else if (ex > signed'({2'b00, CODE_EXT_MAX})) begin
            code_ext = CODE_EXT_MAX;
        end else begin
            code_ext = ex[7:0];
        end
        // scale read from the stored config, so a write lands next time [R3] [R4]
        code = q.cfg[CFG_EXT] ? code_ext : code_std;
        // [R19]
        frac = {conv_in.temp[3:0], 4'h0}
            & (ch ? FRAC_FULL : RES_MASK[q.cfg[CFG_RES +: 2]]);
        hi = q.lim[{ch, 1'b0}];
        lo = q.lim[{ch, 1'b1}];
        cr = q.lim[LIM_CRIT + int'(ch)];
        vh = code > hi;
        vl = code < lo;
        rd_idx = (axil_req_in.araddr - ADDR_LIM_BASE) >> 2;

        aw_hs = axil_req_in.awvalid & q.rsp.awready;
        w_hs = axil_req_in.wvalid & q.rsp.wready;
        ar_hs = axil_req_in.arvalid & q.rsp.arready;

        // write path: address and data in either order
        if (aw_hs) begin
            d.aw_got = 1'b1;
            d.aw_addr = axil_req_in.awaddr;
        end
        if (w_hs) begin
            d.w_got = 1'b1;
            d.w_byte = axil_req_in.wdata[7:0];
            d.w_en = axil_req_in.wstrb[0];
        end
        if (q.rsp.bvalid & axil_req_in.bready) begin
            d.rsp.bvalid = 1'b0;
        end
        if (d.aw_got & d.w_got & !d.rsp.bvalid) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.rsp.bvalid = 1'b1;
            d.rsp.bresp = RESP_OKAY;
            // limits are stored as written, never reformatted [R18]
            if (d.aw_addr >= ADDR_LIM_BASE && d.aw_addr <= ADDR_LIM_LAST
                && d.aw_addr[1:0] == 2'b00) begin
                if (d.w_en) begin
                    d.lim[3'((d.aw_addr - ADDR_LIM_BASE) >> 2)] = d.w_byte;
                end
            end else begin
                case (d.aw_addr)
                    ADDR_CFG: begin
                        if (d.w_en) begin
                            d.cfg = d.w_byte;
                        end
                    end
                    ADDR_HYST: begin
                        if (d.w_en) begin
                            d.hyst = d.w_byte;
                        end
                    end
                    ADDR_CONSEC: begin
                        if (d.w_en) begin
                            d.consec = d.w_byte[1:0];
                        end
                    end
                    ADDR_LOC_TEMP, ADDR_REM_TEMP, ADDR_STAT, ADDR_ACK: begin
                        d.rsp.bresp = RESP_OKAY;
                    end
                    default: begin
                        d.rsp.bresp = RESP_SLVERR;
                    end
                endcase
            end
        end

        // read path
        if (q.rsp.rvalid & axil_req_in.rready) begin
            d.rsp.rvalid = 1'b0;
        end
        if (ar_hs) begin
            d.rsp.rvalid = 1'b1;
            d.rsp.rresp = RESP_OKAY;
            d.rsp.rdata = 32'h0000_0000;
            if (axil_req_in.araddr >= ADDR_LIM_BASE
                && axil_req_in.araddr <= ADDR_LIM_LAST
                && axil_req_in.araddr[1:0] == 2'b00) begin
                d.rsp.rdata[7:0] = q.lim[rd_idx[2:0]];
            end else begin
                case (axil_req_in.araddr)
                    ADDR_LOC_TEMP: d.rsp.rdata[15:0] = q.temp[0];
                    ADDR_REM_TEMP: d.rsp.rdata[15:0] = q.temp[1];
                    ADDR_CFG: d.rsp.rdata[7:0] = q.cfg;
                    ADDR_STAT: d.rsp.rdata[7:0] = q.stat;
                    ADDR_HYST: d.rsp.rdata[7:0] = q.hyst;
                    ADDR_CONSEC: d.rsp.rdata[1:0] = q.consec;
                    ADDR_ACK: begin
                        // release only once the cause is gone [R15]
                        if (!(|q.viol_now) && !q.open_now) begin
                            d.stat = q.stat & ~ALERT_MASK;
                        end
                    end
                    default: d.rsp.rresp = RESP_SLVERR;
                endcase
            end
        end

        // conversions run after the clear, so a same-cycle event wins
        if (conv_in.done && supply_ok_in) begin // [R17]
            if (ch && conv_in.diode_open) begin
                // last valid result kept [R16] [R13]
                d.stat[ST_OPEN] = 1'b1;
                d.open_now = 1'b1;
            end else begin
                if (ch) begin
                    d.open_now = 1'b0;
                end
                d.temp[ch] = {code, frac};
                // [R20] [R8] [R9]
                if (code > cr) begin
                    d.crit_hit[ch] = 1'b1;
                end else if ({1'b0, code} + {1'b0, q.hyst} <= {1'b0, cr}) begin
                    d.crit_hit[ch] = 1'b0;
                end
                // [R10]
                if (vh | vl) begin
                    d.sec_hit[ch] = 1'b1;
                end else if ({1'b0, code} + {1'b0, q.hyst} <= {1'b0, hi}
                    && {1'b0, code} >= {1'b0, lo} + {1'b0, q.hyst}) begin
                    d.sec_hit[ch] = 1'b0;
                end
                // consecutive filter on the early warning [R11] [R12]
                d.viol_now[ch] = vh | vl;
                if (vh | vl) begin
                    if (q.cnt[ch] >= q.consec) begin
                        d.stat[ST_LOC_HIGH - 2 * int'(ch)] = d.stat[ST_LOC_HIGH
                            - 2 * int'(ch)] | vh;
                        d.stat[ST_LOC_HIGH - 1 - 2 * int'(ch)] = d.stat[ST_LOC_HIGH
                            - 1 - 2 * int'(ch)] | vl;
                    end
                    if (q.cnt[ch] != CNT_MAX) begin
                        d.cnt[ch] = q.cnt[ch] + 2'h1;
                    end
                end else begin
                    d.cnt[ch] = 2'h0;
                end
            end
        end
        d.stat[ST_LOC_CRIT +: 2] = d.crit_hit;

        // no config bit reaches the critical pin [R6]
        d.crit_oe = |d.crit_hit;
        // [R7] [R14]
        d.p6_oe = d.cfg[CFG_P6] ? |d.sec_hit
            : (!d.cfg[CFG_SUP] && |(d.stat & ALERT_MASK));
        d.pin_lvl = 1'b0;

        // one write and one read at a time; ready drops until the answer is taken
        d.rsp.awready = !d.aw_got && !d.rsp.bvalid;
        d.rsp.wready = !d.w_got && !d.rsp.bvalid;
        d.rsp.arready = !d.rsp.rvalid;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            q <= '0;
            q.rsp.awready <= 1'b1;
            q.rsp.wready <= 1'b1;
            q.rsp.arready <= 1'b1;
            q.cfg <= CFG_RST;
            q.hyst <= HYST_RST;
            q.consec <= CONSEC_RST;
            q.lim <= {LIM_CRIT_RST, LIM_CRIT_RST, LIM_LOW_RST, LIM_HIGH_RST,
                LIM_LOW_RST, LIM_HIGH_RST};
        end else begin
            q <= d;
        end
    end

    assign axil_rsp_out = q.rsp;
    assign critical_overtemp_pin_out = q.pin_lvl;
    assign critical_overtemp_pin_oe_out = q.crit_oe;
    assign second_critical_pin_out = q.pin_lvl;
    assign second_critical_pin_oe_out = q.p6_oe;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence good_conv(logic rem);
        conv_in.done && supply_ok_in && conv_in.remote == rem
            && !conv_in.diode_open;
    endsequence

    sequence ack_clean;
        ar_hs && axil_req_in.araddr == ADDR_ACK && !(|q.viol_now)
            && !q.open_now && !conv_in.done;
    endsequence

    std_negative_a: assert property ( // [R1]
        good_conv(1'b0) and (!q.cfg[CFG_EXT] && conv_in.temp[12])
        |=> q.temp[0][15:8] == CODE_MIN)
        else $error("negative local result not coded as zero");

    std_saturate_a: assert property ( // [R2]
        good_conv(1'b1) and (!q.cfg[CFG_EXT] && !conv_in.temp[12]
        && conv_in.temp[11])
        |=> q.temp[1][15:8] == CODE_STD_MAX)
        else $error("hot remote result not saturated");

    ext_offset_a: assert property ( // [R5]
        good_conv(1'b0) and (q.cfg[CFG_EXT] && conv_in.temp[12:4] == 9'h000)
        |=> q.temp[0][15:8] == 8'h40)
        else $error("extended zero not coded with offset");

    supply_hold_a: assert property ( // [R17]
        !supply_ok_in |=> $stable(q.temp))
        else $error("result changed while supply invalid");

    open_flag_a: assert property ( // [R16]
        conv_in.done && supply_ok_in && conv_in.remote && conv_in.diode_open
        |=> q.stat[ST_OPEN] && $stable(q.temp[1]))
        else $error("diode fault not flagged or result lost");

    crit_set_a: assert property ( // [R8]
        good_conv(1'b0) and (code > q.lim[LIM_CRIT])
        |=> critical_overtemp_pin_oe_out)
        else $error("critical pin not asserted over limit");

    alert_suppress_a: assert property ( // [R14]
        !q.cfg[CFG_P6] && q.cfg[CFG_SUP] |-> !second_critical_pin_oe_out)
        else $error("suppressed alert pin driven");

    alert_first_a: assert property ( // [R12]
        good_conv(1'b1) and (q.consec == 2'h0 && vh && !q.cfg[CFG_P6]
        && !q.cfg[CFG_SUP] && !(|q.sec_hit) && q.cfg == d.cfg)
        |=> second_critical_pin_oe_out ##0 q.stat[ST_REM_LOW + 1])
        else $error("alert missing after single violation");

    ack_release_a: assert property ( // [R15]
        ack_clean |=> (q.stat & ALERT_MASK) == 8'h00)
        else $error("flags not cleared by clean address read");

    read_answer_a: assert property (
        ar_hs |=> axil_rsp_out.rvalid && !axil_rsp_out.arready)
        else $error("read not answered on the next cycle");

endmodule

// ===== design/temp_alarm_pkg.sv
/*
  shared definitions of the temperature result formatter and alarm block:
  register byte addresses, field positions, reset values and bus carriers.
  assumes an AXI4-Lite master with 8-bit addresses and 32-bit data.
*/
package temp_alarm_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_LOC_TEMP = 8'h00;
    localparam logic [7:0] ADDR_REM_TEMP = 8'h04;
    localparam logic [7:0] ADDR_CFG = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_LIM_BASE = 8'h10;
    localparam logic [7:0] ADDR_LIM_LAST = 8'h24;
    localparam logic [7:0] ADDR_HYST = 8'h28;
    localparam logic [7:0] ADDR_CONSEC = 8'h2C;
    localparam logic [7:0] ADDR_ACK = 8'h30;
    // limit array order: loc high, loc low, rem high, rem low, loc crit, rem crit
    localparam int LIM_N = 6;
    localparam int LIM_CRIT = 4;
    // configuration bits
    localparam int CFG_RES = 0;
    localparam int CFG_EXT = 2;
    localparam int CFG_P6 = 5;
    localparam int CFG_SUP = 7;
    // status bits
    localparam int ST_LOC_CRIT = 0;
    localparam int ST_OPEN = 2;
    localparam int ST_REM_LOW = 3;
    localparam int ST_LOC_HIGH = 6;
    localparam logic [7:0] ALERT_MASK = 8'h7C;
    // reset values
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] HYST_RST = 8'h0A;
    localparam logic [7:0] LIM_HIGH_RST = 8'h55;
    localparam logic [7:0] LIM_LOW_RST = 8'h00;
    localparam logic [7:0] LIM_CRIT_RST = 8'h55;
    localparam logic [1:0] CONSEC_RST = 2'h0;
    localparam logic [1:0] CNT_MAX = 2'h3;
    // result coding
    localparam logic [7:0] CODE_MIN = 8'h00;
    localparam logic [7:0] CODE_STD_MAX = 8'h7F;
    localparam logic [7:0] CODE_EXT_MAX = 8'hFF;
    localparam logic signed [9:0] EXT_OFFSET = 10'sh040;
    localparam logic [7:0] FRAC_FULL = 8'hFF;
    // local fraction masks for 0.5, 0.25, 0.125, 0.0625 degree
    localparam logic [3:0][7:0] RES_MASK = {8'hF0, 8'hE0, 8'hC0, 8'h80};
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } axil_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_s;

    // one finished conversion; temp is signed, units of 1/16 degree
    typedef struct packed {
        logic done;
        logic remote;
        logic diode_open;
        logic [12:0] temp;
    } conv_s;
endpackage

// ===== tb/alarm_host_model.sv
/*
  host side of the two open-drain alarm lines: pull-up resistors on each wire.
  assumes the device drives a pin only while its output enable is high.
*/
`timescale 1ns/1ps

module alarm_host_model (
    input wire logic crit_oe_in,
    input wire logic crit_out_in,
    input wire logic p6_oe_in,
    input wire logic p6_out_in,
    output logic crit_level_out,
    output logic p6_level_out
);
    // a released line floats up to the pull-up, never to the last driven value
    assign crit_level_out = crit_oe_in ? crit_out_in : 1'b1;
    assign p6_level_out = p6_oe_in ? p6_out_in : 1'b1;
endmodule

// ===== tb/temp_result_format_and_alarms_bench.sv
/*
  self-checking bench of the temperature formatter and alarm block.
  assumes the block answers over AXI4-Lite and takes one conversion per done pulse.
*/
`timescale 1ns/1ps

module temp_result_format_and_alarms_bench;
    import temp_alarm_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    axil_req_s req = '0;
    axil_rsp_s rsp;
    conv_s conv = '0;
    logic supply_ok = 1'b1;
    logic crit_q, crit_oe, p6_q, p6_oe, crit_level, p6_level;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    int i;

    temp_alarm uut (.clk_in(clk_in), .rst_in(rst_in), .axil_req_in(req), .axil_rsp_out(rsp),
        .conv_in(conv), .supply_ok_in(supply_ok), .critical_overtemp_pin_out(crit_q),
        .critical_overtemp_pin_oe_out(crit_oe), .second_critical_pin_out(p6_q),
        .second_critical_pin_oe_out(p6_oe));
    alarm_host_model host (.crit_oe_in(crit_oe), .crit_out_in(crit_q), .p6_oe_in(p6_oe),
        .p6_out_in(p6_q), .crit_level_out(crit_level), .p6_level_out(p6_level));

    always #20 clk_in = ~clk_in;

    task automatic final_report();
        $display("errors %0d of %0d checks", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // a hung handshake would otherwise stall the run forever
    always @(posedge clk_in) begin
        cycles++;
        if (cycles > 3000) begin
            n_errors++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk_in);
        req.awaddr <= a;
        req.awvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        forever begin
            @(posedge clk_in);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (req.bready && rsp.bvalid) begin
                chk({30'h0, rsp.bresp}, {30'h0, er});
                req.bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk_in);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        forever begin
            @(posedge clk_in);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (req.rready && rsp.rvalid) begin
                chk(rsp.rdata, ed);
                chk({30'h0, rsp.rresp}, {30'h0, er});
                req.rready <= 1'b0;
                break;
            end
        end
    endtask

    // pin expectations are wire levels: 0 means the alarm pulls low
    task automatic pins(input logic ec, input logic ep);
        chk({31'h0, crit_level}, {31'h0, ec});
        chk({31'h0, p6_level}, {31'h0, ep});
    endtask

    task automatic cv(input logic r, input logic o, input logic [12:0] t);
        @(posedge clk_in);
        conv <= {1'b1, r, o, t};
        @(posedge clk_in);
        conv.done <= 1'b0;
        @(posedge clk_in);
        @(posedge clk_in);
    endtask

    initial begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        pins(1'b1, 1'b1);
        rd(ADDR_CFG, 32'h0000_0000, RESP_OKAY);
        rd(ADDR_HYST, 32'h0000_000a, RESP_OKAY);
        rd(ADDR_LIM_BASE, 32'h0000_0055, RESP_OKAY);
        rd(8'h40, 32'h0000_0000, RESP_SLVERR);
        wr(8'h40, 32'h0000_0001, RESP_SLVERR);
        wr(ADDR_STAT, 32'h0000_00ff, RESP_OKAY);
        rd(ADDR_STAT, 32'h0000_0000, RESP_OKAY);
        wr(ADDR_LIM_BASE, 32'h0000_0070, RESP_OKAY);
        cv(1'b0, 1'b0, 13'h1fb0);
        rd(ADDR_LOC_TEMP, 32'h0000_0000, RESP_OKAY);
        pins(1'b1, 1'b1);
        cv(1'b0, 1'b0, 13'h0828);
        rd(ADDR_LOC_TEMP, 32'h0000_7f80, RESP_OKAY);
        pins(1'b0, 1'b0);
        rd(ADDR_ACK, 32'h0000_0000, RESP_OKAY);
        pins(1'b0, 1'b0);
        cv(1'b0, 1'b0, 13'h04c0);
        pins(1'b0, 1'b0);
        cv(1'b0, 1'b0, 13'h04b0);
        pins(1'b1, 1'b0);
        rd(ADDR_STAT, 32'h0000_0040, RESP_OKAY);
        rd(ADDR_ACK, 32'h0000_0000, RESP_OKAY);
        pins(1'b1, 1'b1);
        rd(ADDR_STAT, 32'h0000_0000, RESP_OKAY);
        wr(ADDR_CONSEC, 32'h0000_0002, RESP_OKAY);
        for (i = 0; i < 3; i++) begin
            cv(1'b0, 1'b0, 13'h0780);
            pins(1'b0, i < 2);
        end
        cv(1'b0, 1'b0, 13'h0140);
        rd(ADDR_ACK, 32'h0000_0000, RESP_OKAY);
        pins(1'b1, 1'b1);
        wr(ADDR_CONSEC, 32'h0000_0000, RESP_OKAY);
        wr(ADDR_CFG, 32'h0000_0080, RESP_OKAY);
        cv(1'b0, 1'b0, 13'h0780);
        pins(1'b0, 1'b1);
        wr(ADDR_CFG, 32'h0000_0000, RESP_OKAY);
        pins(1'b0, 1'b0);
        cv(1'b0, 1'b0, 13'h0140);
        rd(ADDR_ACK, 32'h0000_0000, RESP_OKAY);
        cv(1'b1, 1'b1, 13'h0780);
        rd(ADDR_REM_TEMP, 32'h0000_0000, RESP_OKAY);
        rd(ADDR_STAT, 32'h0000_0004, RESP_OKAY);
        pins(1'b1, 1'b0);
        cv(1'b1, 1'b0, 13'h0141);
        rd(ADDR_REM_TEMP, 32'h0000_1410, RESP_OKAY);
        rd(ADDR_ACK, 32'h0000_0000, RESP_OKAY);
        pins(1'b1, 1'b1);
        // hot remote reading: saturates, trips both alarms on the far channel
        cv(1'b1, 1'b0, 13'h0828);
        rd(ADDR_REM_TEMP, 32'h0000_7f80, RESP_OKAY);
        rd(ADDR_STAT, 32'h0000_0012, RESP_OKAY);
        pins(1'b0, 1'b0);
        cv(1'b1, 1'b0, 13'h0141);
        rd(ADDR_ACK, 32'h0000_0000, RESP_OKAY);
        pins(1'b1, 1'b1);
        supply_ok <= 1'b0;
        cv(1'b0, 1'b0, 13'h0320);
        supply_ok <= 1'b1;
        rd(ADDR_LOC_TEMP, 32'h0000_1400, RESP_OKAY);
        wr(ADDR_CFG, 32'h0000_0007, RESP_OKAY);
        rd(ADDR_LOC_TEMP, 32'h0000_1400, RESP_OKAY);
        cv(1'b0, 1'b0, 13'h0195);
        rd(ADDR_LOC_TEMP, 32'h0000_5950, RESP_OKAY);
        cv(1'b0, 1'b0, 13'h1e70);
        rd(ADDR_LOC_TEMP, 32'h0000_2700, RESP_OKAY);
        cv(1'b0, 1'b0, 13'h0000);
        rd(ADDR_LOC_TEMP, 32'h0000_4000, RESP_OKAY);
        rd(ADDR_LIM_BASE, 32'h0000_0070, RESP_OKAY);
        wr(ADDR_CFG, 32'h0000_0020, RESP_OKAY);
        wr(8'h14, 32'h0000_0010, RESP_OKAY);
        cv(1'b0, 1'b0, 13'h0050);
        pins(1'b1, 1'b0);
        cv(1'b0, 1'b0, 13'h0190);
        pins(1'b1, 1'b0);
        cv(1'b0, 1'b0, 13'h01a0);
        pins(1'b1, 1'b1);
        final_report();
    end
endmodule
